// file: sep_pkg.sv
// shared constants and types of the serial eeprom command port
package sep_pkg;
  // timing
  localparam int CLK_NS = 4;
  localparam int T_CSL_NS = 250;
  localparam int T_CSL_CYC = (T_CSL_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_TIME_NS = 4000000;
  // array shape
  localparam int MEM_WORDS = 128;
  localparam int ADDR_W_X8 = 9;
  localparam int ADDR_W_X16 = 8;
  localparam int DATA_W_X8 = 8;
  localparam int DATA_W_X16 = 16;
  // opcodes after the start bit
  localparam logic [1:0] OPC_SPECIAL = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  // sub codes in the top address bits of the special opcode
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRALL = 2'h1;
  localparam logic [1:0] SUB_ERALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  // organisation modes
  localparam logic [1:0] ORG_PIN = 2'h0;
  localparam logic [1:0] ORG_X8 = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;
  // pin indices
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DI = 2;
  localparam int PIN_ORG = 3;
  localparam int NUM_PINS = 4;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } sep_pin_t;

  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [1:0] be;
    logic [15:0] data;
  } sep_wr_t;

  typedef struct packed {
    logic all;
    logic [6:0] addr;
    logic [1:0] be;
    logic [15:0] data;
  } sep_req_t;
endpackage

// file: sep_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module sep_pin_sync
  import sep_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // pin and result
  input wire logic pin,
  output var sep_pin_t ev
);
  logic s1, s2, s3;
  logic next_lvl;
  sep_pin_t next_ev;

  // level changes only once stages two and three agree
  always_comb begin
    next_lvl = (s2 == s3) ? s3 : ev.level;
    next_ev.level = next_lvl;
    next_ev.rise = next_lvl & ~ev.level;
    next_ev.fall = ~next_lvl & ev.level;
  end

  // register chain and filtered level
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      ev <= '0;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      ev <= next_ev;
    end
  end
endmodule
`default_nettype wire

// file: sep_mem.sv
// word array with byte lanes and registered read data
`timescale 1ns/1ps
`default_nettype none
module sep_mem
  import sep_pkg::*;
#(
  parameter int WORDS = MEM_WORDS
) (
  // clocking
  input wire logic clk,
  input wire logic ce,
  // write port
  input wire sep_wr_t wr,
  // read port
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [WORDS];

  // byte-lane write and registered read
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr.en && wr.be[0]) begin
        mem[wr.addr][7:0] <= wr.data[7:0];
      end
      if (wr.en && wr.be[1]) begin
        mem[wr.addr][15:8] <= wr.data[15:8];
      end
      if (rd_en) begin
        rd_data <= mem[rd_addr];
      end
    end
  end
endmodule
`default_nettype wire

// file: sep_core.sv
// serial eeprom command port: decoder, read stream and self-timed programming
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1 - after reset programming is disabled; erase and write refused until enabled
// RQ2 - enable state holds across instructions until a disable instruction
// RQ3 - read behaves the same whether programming is enabled or not
// RQ4 - read sends one dummy zero, then an 8 or 16 bit word
// RQ5 - read output bits change on serial clock rising edges
// RQ6 - with select held high, read continues into the next word
// RQ7 - host shifts exactly one data word after write opcode and address
// RQ8 - low-voltage starts programming on select fall, fixed supply on last clock
// RQ9 - select raised after 250 ns low shows busy 0, ready 1
// RQ10 - after completion a start bit then select low removes the status
// RQ11 - write-all fills every location, only when programming is enabled
// RQ12 - a started programming cycle finishes without serial clocks
// RQ13 - select low goes to standby, but a running cycle still completes
// RQ14 - host keeps select low at least 250 ns between instructions
// RQ15 - select low holds the decoder in reset and ignores the clock
// RQ16 - opcode, address and data are sampled on the rising serial clock
// RQ17 - serial clock may pause at either level and resume
// RQ18 - before a start bit any number of clocks changes nothing
// RQ19 - after execution clock and data are ignored until a new start
// RQ20 - select low throughout keeps output off; a later check reads ready
// RQ21 - width select high gives 16-bit words, low 8-bit; fixed variants exist
// RQ22 - host should disable programming after every programming operation; the bench sends one disable, after all its programming and a read
// RQ23 - start bit is select and data both high at a clock rising edge
// RQ24 - data output turns off on the falling edge of select
// RQ25 - opcodes and address widths follow the instruction table per width
module sep_core
  import sep_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b1,
  parameter logic [1:0] ORG_MODE = ORG_PIN,
  parameter int PROG_CYCLES = PROG_TIME_NS / CLK_NS
) (
  // system clock and control
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CE,
  // serial pins
  input wire logic CS,
  input wire logic SCLK,
  input wire logic SERIAL_DATA_IN,
  input wire logic WORD_WIDTH_SELECT,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OUT_OE,
  // status
  output logic PROG_BUSY,
  output logic PROG_ENABLED
);
  typedef enum {S_IDLE, S_OPC, S_ADDR, S_DATA, S_READ, S_DONE} sep_state_t;

  localparam logic [6:0] CSL_MAX = 7'(T_CSL_CYC);
  localparam logic [6:0] LAST_WORD = 7'(MEM_WORDS - 1);
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  // special sub code sits in the two top address bits
  function automatic logic [1:0] sub_code(input logic [8:0] a, input logic wide);
    sub_code = wide ? a[7:6] : a[8:7];
  endfunction

  sep_pin_t pin_ev [NUM_PINS];
  sep_pin_t cs, sclk, di, word_width_select;
  logic [NUM_PINS-1:0] pins;
  logic x16;
  logic [4:0] alen, dlen;
  logic [15:0] rd_data;
  logic [6:0] rd_waddr;
  logic cur_bit;

  // front-end registers
  sep_state_t st, next_st;
  logic [4:0] cnt, next_cnt;
  logic [1:0] opc, next_opc;
  logic [8:0] addr, next_addr;
  logic [15:0] data, next_data;
  logic en, next_en;
  logic pend, next_pend;
  logic clear_pend, next_clear_pend;
  logic status, next_status;
  logic show, next_show;
  logic [6:0] csl_cnt, next_csl_cnt;
  logic do_out, next_do_out;
  logic do_oe, next_do_oe;
  logic [7:0] rd_addr, next_rd_addr;
  logic [4:0] ridx, next_ridx;
  logic rd_en, next_rd_en;
  logic start, next_start;
  sep_req_t req, next_req;

  // programming registers
  logic busy, next_busy;
  logic [31:0] prog_cnt, next_prog_cnt;
  logic sweeping, next_sweeping;
  logic [6:0] sweep_addr, next_sweep_addr;
  sep_wr_t wr, next_wr;

  // pin synchronisers
  assign pins = {WORD_WIDTH_SELECT, SERIAL_DATA_IN, SCLK, CS};
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_sync
      sep_pin_sync u_sync (
        .clk(CLK_SYS),
        .rst(RESET),
        .ce(CE),
        .pin(pins[i]),
        .ev(pin_ev[i])
      );
    end
  endgenerate
  assign cs = pin_ev[PIN_CS];
  assign sclk = pin_ev[PIN_SCLK];
  assign di = pin_ev[PIN_DI];
  assign word_width_select = pin_ev[PIN_ORG];

  // word organisation and field lengths
  assign x16 = (ORG_MODE == ORG_X16) || ((ORG_MODE == ORG_PIN) && word_width_select.level); // RQ21
  assign alen = x16 ? 5'(ADDR_W_X16) : 5'(ADDR_W_X8); // RQ25
  assign dlen = x16 ? 5'(DATA_W_X16) : 5'(DATA_W_X8);

  // read word and current output bit
  assign rd_waddr = x16 ? rd_addr[6:0] : rd_addr[7:1];
  assign cur_bit = x16 ? rd_data[ridx[3:0]] :
                   (rd_addr[0] ? rd_data[{1'b1, ridx[2:0]}] : rd_data[{1'b0, ridx[2:0]}]);

  sep_mem u_mem (
    .clk(CLK_SYS),
    .ce(CE),
    .wr(wr),
    .rd_en(rd_en),
    .rd_addr(rd_waddr),
    .rd_data(rd_data)
  );

  // instruction decoder, read stream and ready/busy output
  always_comb begin
    logic go;
    logic [8:0] full_addr;
    logic [15:0] full_data;
    go = 1'b0;
    full_addr = {addr[7:0], di.level};
    full_data = {data[14:0], di.level};
    next_st = st;
    next_cnt = cnt;
    next_opc = opc;
    next_addr = addr;
    next_data = data;
    next_en = en;
    next_pend = pend;
    next_clear_pend = clear_pend;
    next_status = status;
    next_show = show;
    next_csl_cnt = csl_cnt;
    next_do_out = do_out;
    next_do_oe = do_oe;
    next_rd_addr = rd_addr;
    next_ridx = ridx;
    next_rd_en = 1'b0;
    next_start = 1'b0;
    next_req = req;
    // select low time, saturating
    if (cs.level) begin
      next_csl_cnt = 7'h00;
    end else if (csl_cnt != CSL_MAX) begin
      next_csl_cnt = csl_cnt + 7'h01;
    end
    if (!cs.level) begin
      next_st = S_IDLE; // RQ15
      if (cs.fall) begin
        next_do_oe = 1'b0; // RQ24
        next_show = 1'b0;
        next_clear_pend = 1'b0;
        if (clear_pend) begin
          next_status = 1'b0; // RQ10
        end
        if (pend) begin
          next_start = 1'b1; // RQ8
          next_pend = 1'b0;
          next_status = 1'b1;
        end
      end
    end else begin
      if (cs.rise && status && csl_cnt == CSL_MAX) begin
        next_show = 1'b1; // RQ9
      end
      if (show) begin
        next_do_oe = 1'b1;
        next_do_out = ~busy; // RQ9 RQ20
      end
      if (sclk.rise) begin // RQ16 RQ17
        case (st)
          S_IDLE: begin
            if (di.level && !busy) begin // RQ23 RQ18
              next_st = S_OPC;
              next_cnt = 5'h00;
              if (status) begin
                next_clear_pend = 1'b1; // RQ10
              end
            end
          end
          S_OPC: begin
            next_opc = {opc[0], di.level};
            if (cnt == 5'h01) begin
              next_st = S_ADDR;
              next_cnt = 5'h00;
            end else begin
              next_cnt = cnt + 5'h01;
            end
          end
          S_ADDR: begin
            next_addr = full_addr;
            next_cnt = cnt + 5'h01;
            if (cnt == alen - 5'h01) begin
              next_cnt = 5'h00;
              next_st = S_DONE;
              next_req.all = 1'b0;
              next_req.addr = x16 ? full_addr[6:0] : full_addr[7:1];
              next_req.be = x16 ? 2'h3 : (full_addr[0] ? 2'h2 : 2'h1);
              next_req.data = 16'hffff;
              case (opc) // RQ25
                OPC_READ: begin
                  next_st = S_READ; // RQ3
                  next_show = 1'b0; // RQ4
                  next_do_oe = 1'b1;
                  next_do_out = 1'b0; // RQ4
                  next_rd_addr = x16 ? {1'b0, full_addr[6:0]} : full_addr[7:0];
                  next_rd_en = 1'b1;
                  next_ridx = dlen - 5'h01;
                end
                OPC_ERASE: go = 1'b1;
                OPC_WRITE: next_st = S_DATA;
                default: begin
                  case (sub_code(full_addr, x16))
                    SUB_ENABLE: next_en = 1'b1; // RQ2
                    SUB_DISABLE: next_en = 1'b0; // RQ2
                    SUB_ERALL: begin
                      next_req.all = 1'b1;
                      next_req.be = 2'h3;
                      go = 1'b1;
                    end
                    default: next_st = S_DATA;
                  endcase
                end
              endcase
            end
          end
          S_DATA: begin
            next_data = full_data;
            next_cnt = cnt + 5'h01;
            if (cnt == dlen - 5'h01) begin // RQ7
              next_st = S_DONE;
              go = 1'b1;
              next_req.data = x16 ? full_data : {full_data[7:0], full_data[7:0]};
              if (opc == OPC_SPECIAL) begin
                next_req.all = 1'b1; // RQ11
                next_req.be = 2'h3;
              end
            end
          end
          S_READ: begin
            next_do_out = cur_bit; // RQ5
            if (ridx == 5'h00) begin
              next_ridx = dlen - 5'h01; // RQ6
              next_rd_addr = x16 ? {1'b0, rd_addr[6:0] + 7'h01} : rd_addr + 8'h01;
              next_rd_en = 1'b1;
            end else begin
              next_ridx = ridx - 5'h01;
            end
          end
          S_DONE: next_st = S_DONE; // RQ19
          default: next_st = S_IDLE;
        endcase
      end
    end
    // refused without the enable latch
    if (go && en) begin // RQ1 RQ11
      if (LOW_VOLTAGE) begin
        next_pend = 1'b1; // RQ8
      end else begin
        next_start = 1'b1; // RQ8
        next_status = 1'b1;
      end
    end
  end

  // front-end state registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      st <= S_IDLE;
      cnt <= 5'h00;
      opc <= 2'h0;
      addr <= 9'h000;
      data <= 16'h0000;
      en <= 1'b0; // RQ1
      pend <= 1'b0;
      clear_pend <= 1'b0;
      status <= 1'b0;
      show <= 1'b0;
      csl_cnt <= 7'h00;
      do_out <= 1'b0;
      do_oe <= 1'b0;
      rd_addr <= 8'h00;
      ridx <= 5'h00;
      rd_en <= 1'b0;
      start <= 1'b0;
      req <= '0;
    end else if (CE) begin
      st <= next_st;
      cnt <= next_cnt;
      opc <= next_opc;
      addr <= next_addr;
      data <= next_data;
      en <= next_en;
      pend <= next_pend;
      clear_pend <= next_clear_pend;
      status <= next_status;
      show <= next_show;
      csl_cnt <= next_csl_cnt;
      do_out <= next_do_out;
      do_oe <= next_do_oe;
      rd_addr <= next_rd_addr;
      ridx <= next_ridx;
      rd_en <= next_rd_en;
      start <= next_start;
      req <= next_req;
    end
  end

  // self-timed erase and program cycle
  always_comb begin
    next_busy = busy;
    next_prog_cnt = prog_cnt;
    next_sweeping = sweeping;
    next_sweep_addr = sweep_addr;
    next_wr = '0;
    if (start && !busy) begin
      next_busy = 1'b1;
      next_prog_cnt = 32'h0000_0000;
      if (req.all) begin
        next_sweeping = 1'b1; // RQ11
        next_sweep_addr = 7'h00;
      end else begin
        next_wr = {1'b1, req.addr, req.be, req.data};
      end
    end else if (busy) begin
      if (sweeping) begin
        next_wr = {1'b1, sweep_addr, 2'h3, req.data}; // RQ11
        next_sweep_addr = sweep_addr + 7'h01;
        if (sweep_addr == LAST_WORD) begin
          next_sweeping = 1'b0;
        end
      end
      if (prog_cnt == PROG_LAST) begin // RQ12 RQ13
        next_busy = 1'b0;
      end else begin
        next_prog_cnt = prog_cnt + 32'h0000_0001;
      end
    end
  end

  // programming registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      busy <= 1'b0;
      prog_cnt <= 32'h0000_0000;
      sweeping <= 1'b0;
      sweep_addr <= 7'h00;
      wr <= '0;
    end else if (CE) begin
      busy <= next_busy;
      prog_cnt <= next_prog_cnt;
      sweeping <= next_sweeping;
      sweep_addr <= next_sweep_addr;
      wr <= next_wr;
    end
  end

  // outputs straight from registers
  assign SERIAL_DATA_OUT = do_out;
  assign SERIAL_DATA_OUT_OE = do_oe;
  assign PROG_BUSY = busy;
  assign PROG_ENABLED = en;
endmodule
`default_nettype wire

// file: sep_core_properties.sv
// concurrent checks on the pins of the serial eeprom command port
`timescale 1ns/1ps
`default_nettype none
module sep_core_properties
  import sep_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b1,
  parameter int PROG_CYCLES = 200
) (
  // system clock and control
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CE,
  // serial pins
  input wire logic CS,
  input wire logic SCLK,
  input wire logic SERIAL_DATA_IN,
  input wire logic WORD_WIDTH_SELECT,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OUT_OE,
  // status
  input wire logic PROG_BUSY,
  input wire logic PROG_ENABLED
);
  int busy_cnt, cs_hi, since_rise;
  int next_busy_cnt, next_cs_hi, next_since_rise;
  logic sclk_q;
  // busy width, select high time, cycles since a clock rise
  always_comb begin
    next_busy_cnt = PROG_BUSY ? busy_cnt + 1 : 0;
    next_cs_hi = CS ? (cs_hi < 255 ? cs_hi + 1 : cs_hi) : 0;
    next_since_rise = (SCLK && !sclk_q) ? 0 : (since_rise < 255 ? since_rise + 1 : 255);
  end
  always_ff @(posedge CLK_SYS) begin
    sclk_q <= RESET ? 1'b0 : SCLK;
    busy_cnt <= RESET ? 0 : next_busy_cnt;
    cs_hi <= RESET ? 0 : next_cs_hi;
    since_rise <= RESET ? 255 : next_since_rise;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence cs_low_run;
    !CS [*8];
  endsequence
  sequence ready_seen;
    $fell(PROG_BUSY) && SERIAL_DATA_OUT_OE;
  endsequence
  AST_OE_OFF_CS_LOW: assert property (cs_low_run |-> !SERIAL_DATA_OUT_OE)
    else $error("data out driven while deselected");
  AST_ENABLE_HOLD: assert property (cs_low_run |=> $stable(PROG_ENABLED))
    else $error("enable latch moved while deselected");
  AST_BUSY_NEEDS_ENABLE: assert property ($rose(PROG_BUSY) |-> PROG_ENABLED)
    else $error("program cycle without enable");
  AST_BUSY_WIDTH: assert property ($fell(PROG_BUSY) |->
    busy_cnt >= PROG_CYCLES - 1 && busy_cnt <= PROG_CYCLES + 1)
    else $error("program cycle length wrong");
  AST_BUSY_ON_CS_FALL: assert property ($rose(PROG_BUSY) && LOW_VOLTAGE |-> !CS)
    else $error("program cycle began while selected");
  AST_STATUS_BUSY: assert property (SERIAL_DATA_OUT_OE && PROG_BUSY && $past(PROG_BUSY, 3)
    |-> !SERIAL_DATA_OUT)
    else $error("status not low while busy");
  AST_READY_AFTER: assert property (ready_seen |-> ##[0:2] SERIAL_DATA_OUT)
    else $error("ready not shown after cycle");
  AST_DUMMY_ZERO: assert property ($rose(SERIAL_DATA_OUT_OE) && cs_hi > 20
    |-> !SERIAL_DATA_OUT)
    else $error("read did not start with zero");
  AST_OUT_ON_SCLK: assert property ($changed(SERIAL_DATA_OUT) && SERIAL_DATA_OUT_OE
    && $past(SERIAL_DATA_OUT_OE) && !$past(PROG_BUSY) && !$past(PROG_BUSY, 2)
    |-> since_rise >= 2 && since_rise <= 10)
    else $error("read bit changed away from clock rise");
endmodule
`default_nettype wire

// file: sep_host_model.sv
// host controller model driving the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module sep_host_model (
  // system clock
  input wire logic clk,
  // serial link
  output logic cs,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  // link idles deselected with its clock still
  initial begin
    cs = 1'b0;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // select, then let the pin filter settle
  task automatic open_frame();
    @(negedge clk);
    cs = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  // deselect for longer than the minimum low time
  task automatic close_frame();
    @(negedge clk);
    cs = 1'b0;
    sdi = 1'b0;
    repeat (70) @(negedge clk);
  endtask
  // n bits msb first at 64 ns, data stable around each rise
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = v[i];
      repeat (8) @(negedge clk);
      q = {q[30:0], sdo};
      sclk = 1'b1;
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: tb_sep_core.sv
// self-checking bench of the serial eeprom command port
`timescale 1ns/1ps
`default_nettype none
module tb_sep_core;
  import sep_pkg::*;
  logic CLK_SYS, RESET, word_width_select, last_do;
  wire logic cs, sclk, sdi, dout, oe, busy, en, do_line;
  logic [31:0] rq;
  int fail_count = 0;
  int samples_checked = 0;
  sep_core #(.LOW_VOLTAGE(1'b1), .ORG_MODE(ORG_PIN), .PROG_CYCLES(200)) i_sep_core (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .CE(1'b1), .CS(cs), .SCLK(sclk),
    .SERIAL_DATA_IN(sdi), .WORD_WIDTH_SELECT(word_width_select), .SERIAL_DATA_OUT(dout),
    .SERIAL_DATA_OUT_OE(oe), .PROG_BUSY(busy), .PROG_ENABLED(en));
  sep_host_model i_sep_host_model (.clk(CLK_SYS), .cs(cs), .sclk(sclk), .sdi(sdi),
    .sdo(do_line));
  // released data line shows the inverse of its last value
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      last_do <= 1'b0;
    end else if (oe) begin
      last_do <= dout;
    end
  end
  assign do_line = oe ? dout : ~last_do;
  // 250 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic sh(input logic [31:0] v, input int n);
    i_sep_host_model.shift(v, n, rq);
  endtask
  task automatic cmd(input logic [31:0] v, input int n);
    i_sep_host_model.open_frame();
    sh(v, n);
    i_sep_host_model.close_frame();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge CLK_SYS);
      n++;
    end
    repeat (4) @(negedge CLK_SYS);
    chk(busy, 1'b0);
  endtask
  // start bit then deselect clears the status
  task automatic clear_status();
    sh(32'h1, 1);
    i_sep_host_model.close_frame();
    i_sep_host_model.open_frame();
    chk(oe, 1'b0);
    i_sep_host_model.close_frame();
  endtask
  // write before enable is refused
  task automatic t_refused();
    cmd({5'h0, 1'b1, 2'b01, 8'h05, 16'h1234}, 32);
    chk(busy, 1'b0);
    i_sep_host_model.open_frame();
    chk(oe, 1'b0);
    i_sep_host_model.close_frame();
  endtask
  // enable with idle clocks before and ignored clocks after
  task automatic t_enable();
    cmd({5'h0, 1'b1, 2'b00, 8'hc0, 4'h0}, 20);
    chk(en, 1'b1);
  endtask
  // write-all with select low for the whole cycle
  task automatic t_write_whole_array_cmd();
    cmd({1'b1, 2'b00, 8'h40, 16'h3c5a}, 27);
    wait_idle();
    chk(oe, 1'b0);
    i_sep_host_model.open_frame();
    chk({oe, dout}, 2'h3);
    clear_status();
  endtask
  // single write and word erase with busy then ready polled
  task automatic t_write();
    cmd({1'b1, 2'b01, 8'h05, 16'ha5c3}, 27);
    chk(busy, 1'b1);
    i_sep_host_model.open_frame();
    chk({oe, dout}, 2'h2);
    wait_idle();
    chk({oe, dout}, 2'h3);
    clear_status();
    cmd({1'b1, 2'b11, 8'h07}, 11);
    wait_idle();
    i_sep_host_model.open_frame();
    clear_status();
    chk(en, 1'b1);
  endtask
  // x16 read across a word boundary with a clock pause
  task automatic t_read16();
    i_sep_host_model.open_frame();
    sh({1'b1, 2'b10, 8'h04}, 11);
    sh(32'h0, 17);
    chk(rq[16:0], {1'b0, 16'h3c5a});
    repeat (40) @(negedge CLK_SYS);
    sh(32'h0, 16);
    chk(rq[15:0], 16'ha5c3);
    sh(32'h0, 32);
    chk(rq, {16'h3c5a, 16'hffff});
    i_sep_host_model.close_frame();
  endtask
  // disable then read, then x8 byte reads
  task automatic t_disabled_x8();
    cmd({1'b1, 2'b00, 8'h00}, 11);
    chk(en, 1'b0);
    i_sep_host_model.open_frame();
    sh({1'b1, 2'b10, 8'h05}, 11);
    sh(32'h0, 17);
    chk(rq[16:0], {1'b0, 16'ha5c3});
    i_sep_host_model.close_frame();
    word_width_select = 1'b0;
    i_sep_host_model.open_frame();
    sh({1'b1, 2'b10, 9'h00b}, 12);
    sh(32'h0, 17);
    chk(rq[16:0], {1'b0, 8'ha5, 8'h5a});
    i_sep_host_model.close_frame();
  endtask
  // watchdog far beyond the roughly 24 us the sequence needs
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  // reset, then the scenarios in order
  initial begin
    RESET = 1'b1;
    word_width_select = 1'b1;
    repeat (12) @(negedge CLK_SYS);
    RESET = 1'b0;
    repeat (8) @(negedge CLK_SYS);
    t_refused();
    t_enable();
    t_write_whole_array_cmd();
    t_write();
    t_read16();
    t_disabled_x8();
    stop_test();
  end
endmodule
bind sep_core sep_core_properties #(.LOW_VOLTAGE(LOW_VOLTAGE), .PROG_CYCLES(PROG_CYCLES))
  i_sep_core_properties (.CLK_SYS(CLK_SYS), .RESET(RESET), .CE(CE), .CS(CS), .SCLK(SCLK),
  .SERIAL_DATA_IN(SERIAL_DATA_IN), .WORD_WIDTH_SELECT(WORD_WIDTH_SELECT),
  .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE),
  .PROG_BUSY(PROG_BUSY), .PROG_ENABLED(PROG_ENABLED));
`default_nettype wire
